// [tcp_pkg.sv]
// Purpose: Shared constants and types for the redriver pin/power control
// Assumes: 40 MHz reference clock, pins sensed through weak pull up/down
// Notes:   Times are kept in their own unit, cycle counts derive from them
package tcp_pkg;

	localparam int CLK_NS     = 25;
	localparam int MS_NS      = 1000000;
	localparam int MS_CYC     = MS_NS / CLK_NS;
	localparam int SETTLE_NS  = 500;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int EXIT_NS    = 1000;
	localparam int EXIT_CYC   = EXIT_NS / CLK_NS;
	localparam int RCFG_MS    = 115;
	localparam int WAKE_MS    = 6;
	localparam int APPLY_MS   = 4;
	localparam int IDLE_MS    = 300;
	localparam int IDLE_MAX_MS = 400;

	// Three-level pin code, the fourth code is never produced
	typedef enum logic [1:0] {
		TRI_LOW  = 2'h0,
		TRI_OPEN = 2'h1,
		TRI_HIGH = 2'h2
	} tcp_tri_t;

	// Gray order along deep -> wake -> active -> saving
	typedef enum logic [1:0] {
		ST_DEEP   = 2'h0,
		ST_WAKE   = 2'h1,
		ST_ACTIVE = 2'h3,
		ST_SAVE   = 2'h2
	} tcp_state_t;

	localparam logic [1:0] EQ_3DB  = 2'h0;
	localparam logic [1:0] EQ_6DB  = 2'h1;
	localparam logic [1:0] EQ_9DB  = 2'h2;
	localparam logic [1:0] DE_0DB  = 2'h0;
	localparam logic [1:0] DE_3P1  = 2'h1;
	localparam logic [1:0] DE_5P3  = 2'h2;
	localparam logic [1:0] SW_0V9  = 2'h0;
	localparam logic [1:0] SW_1V0  = 2'h1;
	localparam logic [1:0] SW_1V1  = 2'h2;

	typedef struct packed {
		logic [1:0] tx_deemphasis_level;
		logic [1:0] tx_output_swing;
	} tcp_tx_prof_t;

	localparam logic [11:0] REG_STATUS = 12'h000;
	localparam logic [11:0] REG_CTRL   = 12'h004;

	localparam int CTRL_RESAMPLE = 0;
	localparam int CTRL_IDLE_LSB = 8;
	localparam int CTRL_IDLE_W   = 10;
	localparam logic [9:0] CTRL_IDLE_RST = 10'h12c;

	localparam int ST_STATE_LSB = 0;
	localparam int ST_LSTB_LSB  = 2;
	localparam int ST_RSTB_LSB  = 4;
	localparam int ST_LLAT_LSB  = 6;
	localparam int ST_RLAT_LSB  = 8;
	localparam int ST_CE_BIT    = 10;
	localparam int ST_TERM_LSB  = 11;

endpackage

// [tcp_tick_div.sv]
// Purpose: Divider giving a one-cycle enable every DIV clocks
// Assumes: DIV of two or more
// Notes:   Paces all millisecond counting of the controller
`timescale 1ns/1ps
`default_nettype none
module tcp_tick_div #(
	parameter int DIV = 40000
) (
	input  wire logic clk,
	input  wire logic rst_n,
	output logic      tick
);
	localparam int CW = $clog2(DIV);

	logic [CW-1:0] cnt_ff;
	logic          tick_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else if (cnt_ff == CW'(DIV - 1)) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b1;
		end else begin
			cnt_ff  <= cnt_ff + 1'b1;
			tick_ff <= 1'b0;
		end
	end

	assign tick = tick_ff;
endmodule
`default_nettype wire

// [tcp_tern_filt.sv]
// Purpose: Synchronise and settle one three-level configuration pin
// Assumes: pu_sense/pd_sense read the pin under weak pull-up/pull-down
// Notes:   Code only moves after SETTLE + 1 equal samples in a row
`timescale 1ns/1ps
`default_nettype none
module tcp_tern_filt #(
	parameter int SETTLE = tcp_pkg::SETTLE_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       pu_sense,
	input  wire logic       pd_sense,
	output tcp_pkg::tcp_tri_t code
);
	localparam int CW = $clog2(SETTLE + 1);

	logic [1:0]        meta_ff;
	logic [1:0]        sync_ff;
	tcp_pkg::tcp_tri_t cand_ff;
	tcp_pkg::tcp_tri_t code_ff;
	tcp_pkg::tcp_tri_t dec;
	logic [CW-1:0]     cnt_ff;

	// Driven pins read the same under both pulls, a floating one follows
	// the pull; a contradictory pair is taken as open
	function automatic tcp_pkg::tcp_tri_t decode(input logic [1:0] s);
		unique case (s)
			2'b11:   decode = tcp_pkg::TRI_HIGH;
			2'b00:   decode = tcp_pkg::TRI_LOW;
			default: decode = tcp_pkg::TRI_OPEN;
		endcase
	endfunction

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_ff <= 2'h2;
			sync_ff <= 2'h2;
		end else begin
			meta_ff <= {pu_sense, pd_sense};
			sync_ff <= meta_ff;
		end
	end

	assign dec = decode(sync_ff);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cand_ff <= tcp_pkg::TRI_OPEN;
			code_ff <= tcp_pkg::TRI_OPEN;
			cnt_ff  <= '0;
		end else if (dec != cand_ff) begin
			cand_ff <= dec;
			cnt_ff  <= '0;
		end else if (cnt_ff != CW'(SETTLE - 1)) begin
			cnt_ff  <= cnt_ff + 1'b1;
		end else begin
			code_ff <= cand_ff;
		end
	end

	assign code = code_ff;
endmodule
`default_nettype wire

// [tcp_ctrl.sv]
// Purpose: Pin profile decode and power state sequencing for a redriver
// Assumes: Pin senses and link conditions are synchronous to REF_CLK
// Notes:   APB gives status and an idle-time override
// Notes on behaviour
// - Each pin decodes to low, open, high
// - Left pin: A transmit, B receive settings
// - High selects long-trace profile
// - Open selects medium-trace profile
// - Low with other pin up: short-trace profile
// - Right pin: B transmit, A receive settings
// - Both low enters deep saving within 115ms
// - Pin raised leaves deep saving within 1us
// - Settings latched 6ms after wake
// - Later changes latch every 115ms
// - Chip enable low only when both low
// - State from pins and link levels only; an APB resample write and the idle-time register also steer it
// - Active: pass data, termination indication held
// - Saving: channels on, squelch and detect running
// - Deep saving: all terminations open
// - Report far-end termination per transmitter
// - Idle 300ms before entering saving state
`timescale 1ns/1ps
`default_nettype none
module tcp_ctrl #(
	parameter int MS_CYCLES = tcp_pkg::MS_CYC
) (
	input  wire logic                 REF_CLK,
	input  wire logic                 RST_N,
	input  wire logic                 LEFT_SIDE_CONFIG_PIN_PU,
	input  wire logic                 LEFT_SIDE_CONFIG_PIN_PD,
	input  wire logic                 RIGHT_SIDE_CONFIG_PIN_PU,
	input  wire logic                 RIGHT_SIDE_CONFIG_PIN_PD,
	input  wire logic                 LINK_IDLE_A,
	input  wire logic                 LINK_IDLE_B,
	input  wire logic                 FAR_TERM_A,
	input  wire logic                 FAR_TERM_B,
	output logic                      CHIP_EN,
	output tcp_pkg::tcp_state_t       POWER_STATE,
	output logic                      CHAN_EN,
	output logic                      RX_TERM_IND,
	output logic                      TERM_DET_EN,
	output logic                      SQUELCH_DET_EN,
	output logic                      TERM_OPEN,
	output logic [1:0]                TERM_PRESENT,
	output tcp_pkg::tcp_tx_prof_t     CHA_TX_PROFILE,
	output tcp_pkg::tcp_tx_prof_t     CHB_TX_PROFILE,
	output logic [1:0]                CHA_RX_EQUALIZATION_GAIN,
	output logic [1:0]                CHB_RX_EQUALIZATION_GAIN,
	input  wire logic                 PSEL,
	input  wire logic                 PENABLE,
	input  wire logic                 PWRITE,
	input  wire logic [11:0]          PADDR,
	input  wire logic [31:0]          PWDATA,
	output logic [31:0]               PRDATA,
	output logic                      PREADY,
	output logic                      PSLVERR
);
	localparam logic [6:0] RCFG_LAST = 7'(tcp_pkg::RCFG_MS - 1);
	localparam logic [2:0] WAKE_LAST = 3'(tcp_pkg::WAKE_MS - 1);
	localparam int         EXIT_LIM  = tcp_pkg::EXIT_CYC;
	tcp_pkg::tcp_tri_t     left_stb, right_stb, left_lat_ff, right_lat_ff;
	tcp_pkg::tcp_state_t   st_ff, nxt_st;
	tcp_pkg::tcp_tx_prof_t cha_tx_ff, chb_tx_ff;
	logic [1:0]            cha_eq_ff, chb_eq_ff, term_ff;
	logic [6:0]            rcfg_cnt_ff;
	logic [2:0]            wake_cnt_ff;
	logic [9:0]            idle_cnt_ff, idle_ms_ff;
	logic [31:0]           prdata_ff;
	logic                  ms_tick, both_low, ce_ff, resample_ff, pslverr_ff;
	logic                  rcfg_tick, wake_done, idle_all, idle_done, deep_go;
	logic                  latch_en, run_st, addr_hit;
	tcp_tick_div #(.DIV(MS_CYCLES)) u_ms (
		.clk   (REF_CLK),
		.rst_n (RST_N),
		.tick  (ms_tick)
	);

	tcp_tern_filt u_left (
		.clk      (REF_CLK),
		.rst_n    (RST_N),
		.pu_sense (LEFT_SIDE_CONFIG_PIN_PU),
		.pd_sense (LEFT_SIDE_CONFIG_PIN_PD),
		.code     (left_stb)
	);

	tcp_tern_filt u_right (
		.clk      (REF_CLK),
		.rst_n    (RST_N),
		.pu_sense (RIGHT_SIDE_CONFIG_PIN_PU),
		.pd_sense (RIGHT_SIDE_CONFIG_PIN_PD),
		.code     (right_stb)
	);

	function automatic tcp_pkg::tcp_tx_prof_t tx_prof(
		input tcp_pkg::tcp_tri_t c);
		unique case (c)
			tcp_pkg::TRI_HIGH: tx_prof = {tcp_pkg::DE_5P3, tcp_pkg::SW_1V1};
			tcp_pkg::TRI_LOW:  tx_prof = {tcp_pkg::DE_0DB, tcp_pkg::SW_0V9};
			default:           tx_prof = {tcp_pkg::DE_3P1, tcp_pkg::SW_1V0};
		endcase
	endfunction
	function automatic logic [1:0] rx_eq(input tcp_pkg::tcp_tri_t c);
		unique case (c)
			tcp_pkg::TRI_HIGH: rx_eq = tcp_pkg::EQ_9DB;
			tcp_pkg::TRI_LOW:  rx_eq = tcp_pkg::EQ_3DB;
			default:           rx_eq = tcp_pkg::EQ_6DB;
		endcase
	endfunction
	// Link power commands are never decoded, only line levels matter
	assign both_low  = (left_stb == tcp_pkg::TRI_LOW) &&
		(right_stb == tcp_pkg::TRI_LOW);
	assign run_st    = (st_ff == tcp_pkg::ST_ACTIVE) ||
		(st_ff == tcp_pkg::ST_SAVE);
	assign rcfg_tick = ms_tick && (rcfg_cnt_ff == RCFG_LAST);
	assign wake_done = ms_tick && (wake_cnt_ff == WAKE_LAST);
	assign idle_all  = LINK_IDLE_A && LINK_IDLE_B;
	assign idle_done = ms_tick && idle_all &&
		(idle_cnt_ff == idle_ms_ff - 10'h001);
	assign deep_go   = run_st && (rcfg_tick || resample_ff) && both_low;
	assign latch_en  = !both_low && ((st_ff == tcp_pkg::ST_WAKE &&
		wake_done) || (run_st && (rcfg_tick || resample_ff)));

	always_ff @(posedge REF_CLK) begin
		if (!RST_N)
			ce_ff <= 1'b1;
		else
			ce_ff <= !both_low;
	end

	// Periodic reconfiguration window, restarted by every wake-up
	always_ff @(posedge REF_CLK) begin
		if (!RST_N || !run_st)
			rcfg_cnt_ff <= '0;
		else if (rcfg_tick)
			rcfg_cnt_ff <= '0;
		else if (ms_tick)
			rcfg_cnt_ff <= rcfg_cnt_ff + 7'h01;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N || st_ff != tcp_pkg::ST_WAKE)
			wake_cnt_ff <= '0;
		else if (ms_tick)
			wake_cnt_ff <= wake_cnt_ff + 3'h1;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N || !idle_all || st_ff != tcp_pkg::ST_ACTIVE)
			idle_cnt_ff <= '0;
		else if (ms_tick && !idle_done)
			idle_cnt_ff <= idle_cnt_ff + 10'h001;
	end

	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			tcp_pkg::ST_DEEP:
				if (!both_low)
					nxt_st = tcp_pkg::ST_WAKE;
			tcp_pkg::ST_WAKE:
				if (wake_done)
					nxt_st = both_low ? tcp_pkg::ST_DEEP :
						tcp_pkg::ST_ACTIVE;
			tcp_pkg::ST_ACTIVE:
				if (deep_go)
					nxt_st = tcp_pkg::ST_DEEP;
				else if (idle_done)
					nxt_st = tcp_pkg::ST_SAVE;
			tcp_pkg::ST_SAVE:
				if (deep_go)
					nxt_st = tcp_pkg::ST_DEEP;
				else if (!idle_all && (|term_ff))
					nxt_st = tcp_pkg::ST_ACTIVE;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N)
			st_ff <= tcp_pkg::ST_ACTIVE;
		else
			st_ff <= nxt_st;
	end

	// Reset starts at the medium profile until the first latch
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			left_lat_ff  <= tcp_pkg::TRI_OPEN;
			right_lat_ff <= tcp_pkg::TRI_OPEN;
		end else if (latch_en) begin
			left_lat_ff  <= left_stb;
			right_lat_ff <= right_stb;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			cha_tx_ff <= tx_prof(tcp_pkg::TRI_OPEN);
			chb_tx_ff <= tx_prof(tcp_pkg::TRI_OPEN);
			cha_eq_ff <= tcp_pkg::EQ_6DB;
			chb_eq_ff <= tcp_pkg::EQ_6DB;
		end else begin
			cha_tx_ff <= tx_prof(left_lat_ff);
			chb_eq_ff <= rx_eq(left_lat_ff);
			chb_tx_ff <= tx_prof(right_lat_ff);
			cha_eq_ff <= rx_eq(right_lat_ff);
		end
	end

	// Detection result only refreshes while the detector runs
	always_ff @(posedge REF_CLK) begin
		if (!RST_N || st_ff == tcp_pkg::ST_DEEP)
			term_ff <= 2'h0;
		else if (st_ff == tcp_pkg::ST_SAVE)
			term_ff <= {FAR_TERM_B, FAR_TERM_A};
	end

	assign CHIP_EN        = ce_ff;
	assign POWER_STATE    = st_ff;
	assign CHAN_EN        = st_ff != tcp_pkg::ST_DEEP;
	assign RX_TERM_IND    = (st_ff == tcp_pkg::ST_ACTIVE) ||
		(st_ff == tcp_pkg::ST_WAKE) ||
		(st_ff == tcp_pkg::ST_SAVE && (|term_ff));
	assign TERM_DET_EN    = st_ff == tcp_pkg::ST_SAVE;
	assign SQUELCH_DET_EN = st_ff == tcp_pkg::ST_SAVE;
	assign TERM_OPEN      = st_ff == tcp_pkg::ST_DEEP;
	assign TERM_PRESENT   = term_ff;
	assign CHA_TX_PROFILE = cha_tx_ff;
	assign CHB_TX_PROFILE = chb_tx_ff;
	assign CHA_RX_EQUALIZATION_GAIN = cha_eq_ff;
	assign CHB_RX_EQUALIZATION_GAIN = chb_eq_ff;

	// APB slave: read data and error are formed in the setup cycle
	assign addr_hit = (PADDR == tcp_pkg::REG_STATUS) ||
		(PADDR == tcp_pkg::REG_CTRL);

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			prdata_ff  <= '0;
			pslverr_ff <= 1'b0;
		end else if (PSEL && !PENABLE) begin
			pslverr_ff <= !addr_hit;
			prdata_ff  <= '0;
			if (PADDR == tcp_pkg::REG_STATUS && !PWRITE) begin
				prdata_ff[tcp_pkg::ST_STATE_LSB +: 2] <= st_ff;
				prdata_ff[tcp_pkg::ST_LSTB_LSB +: 2]  <= left_stb;
				prdata_ff[tcp_pkg::ST_RSTB_LSB +: 2]  <= right_stb;
				prdata_ff[tcp_pkg::ST_LLAT_LSB +: 2]  <= left_lat_ff;
				prdata_ff[tcp_pkg::ST_RLAT_LSB +: 2]  <= right_lat_ff;
				prdata_ff[tcp_pkg::ST_CE_BIT]         <= ce_ff;
				prdata_ff[tcp_pkg::ST_TERM_LSB +: 2]  <= term_ff;
			end else if (PADDR == tcp_pkg::REG_CTRL && !PWRITE) begin
				prdata_ff[tcp_pkg::CTRL_IDLE_LSB +: tcp_pkg::CTRL_IDLE_W]
					<= idle_ms_ff;
			end
		end
	end

	// Zero idle time would wrap to a match only after 1024ms, so it is refused
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			idle_ms_ff  <= tcp_pkg::CTRL_IDLE_RST;
			resample_ff <= 1'b0;
		end else begin
			resample_ff <= 1'b0;
			if (PSEL && PENABLE && PWRITE &&
				PADDR == tcp_pkg::REG_CTRL) begin
				resample_ff <= PWDATA[tcp_pkg::CTRL_RESAMPLE];
				if (|PWDATA[tcp_pkg::CTRL_IDLE_LSB +: tcp_pkg::CTRL_IDLE_W])
					idle_ms_ff <= PWDATA[tcp_pkg::CTRL_IDLE_LSB +:
						tcp_pkg::CTRL_IDLE_W];
			end
		end
	end
	assign PRDATA  = prdata_ff;
	assign PREADY  = 1'b1;
	assign PSLVERR = pslverr_ff;
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	sequence s_deep_leave;
		st_ff == tcp_pkg::ST_DEEP && !both_low;
	endsequence
	sequence s_wake_end;
		st_ff == tcp_pkg::ST_WAKE && wake_done && !both_low;
	endsequence
	a_tri_code_legal: assert property (
		left_stb != 2'h3 && right_stb != 2'h3)
		else $error("pin code uses the unused value");
	a_ce_both_low: assert property (
		both_low [*2] |-> !CHIP_EN ##0 $past(CHIP_EN) == !$past(both_low,2))
		else $error("chip enable does not follow pins");
	a_deep_exit: assert property (
		s_deep_leave |=> st_ff == tcp_pkg::ST_WAKE && CHAN_EN)
		else $error("deep state not left after pin raised");
	// Timed from the raw pin, so filter latency counts against the limit
	a_deep_exit_time: assert property (
		TERM_OPEN && $rose(LEFT_SIDE_CONFIG_PIN_PD ||
		RIGHT_SIDE_CONFIG_PIN_PD) |-> ##[1:EXIT_LIM] !TERM_OPEN)
		else $error("wake from deep too slow");
	a_deep_entry: assert property (
		deep_go |=> st_ff == tcp_pkg::ST_DEEP ##0 TERM_OPEN)
		else $error("deep entry missed at sampling tick");
	a_deep_outputs: assert property (
		st_ff == tcp_pkg::ST_DEEP |-> TERM_OPEN && !CHAN_EN &&
		!RX_TERM_IND && !TERM_DET_EN)
		else $error("deep state outputs wrong");
	a_active_outputs: assert property (
		st_ff == tcp_pkg::ST_ACTIVE |-> CHAN_EN && RX_TERM_IND &&
		!TERM_DET_EN && !TERM_OPEN)
		else $error("active state outputs wrong");
	a_save_outputs: assert property (
		st_ff == tcp_pkg::ST_SAVE |-> CHAN_EN && SQUELCH_DET_EN &&
		TERM_DET_EN)
		else $error("saving state outputs wrong");
	a_wake_latch: assert property (
		s_wake_end |=> st_ff == tcp_pkg::ST_ACTIVE &&
		left_lat_ff == $past(left_stb) ##1
		CHA_TX_PROFILE == tx_prof(left_lat_ff))
		else $error("settings not applied at end of wake");
	a_latch_hold: assert property (
		!latch_en |=> $stable(left_lat_ff) && $stable(right_lat_ff))
		else $error("profile changed outside latch point");
	a_right_map: assert property (
		latch_en |-> ##2 CHB_TX_PROFILE == tx_prof($past(right_stb,2)) &&
		CHA_RX_EQUALIZATION_GAIN == rx_eq($past(right_stb,2)))
		else $error("right pin profile mapped wrong");
	a_idle_entry: assert property (
		st_ff == tcp_pkg::ST_ACTIVE && idle_done && !deep_go |=>
		st_ff == tcp_pkg::ST_SAVE)
		else $error("idle time did not lead to saving state");
	a_apb_unmapped: assert property (
		PSEL && !PENABLE && !addr_hit |=> PSLVERR && PRDATA == 32'h0)
		else $error("unmapped access not flagged");
endmodule
`default_nettype wire

// [tcp_gpio_model.sv]
// Purpose: Processor GPIO or strap model for both configuration pins
// Assumes: An open pin reads 1 under pull-up and 0 under pull-down
// Notes:   Levels move only when the bench changes the request
`timescale 1ns/1ps
`default_nettype none
module tcp_gpio_model (
	input  wire tcp_pkg::tcp_tri_t left_lvl,
	input  wire tcp_pkg::tcp_tri_t right_lvl,
	output logic                   left_pu,
	output logic                   left_pd,
	output logic                   right_pu,
	output logic                   right_pd
);
	// Both may drop low together at any moment, no handshake
	// Raising a pin is the only way out of deep saving
	always_comb begin
		left_pu  = (left_lvl != tcp_pkg::TRI_LOW);
		left_pd  = (left_lvl == tcp_pkg::TRI_HIGH);
		right_pu = (right_lvl != tcp_pkg::TRI_LOW);
		right_pd = (right_lvl == tcp_pkg::TRI_HIGH);
	end
endmodule
`default_nettype wire

// [tcp_ctrl_test.sv]
// Purpose: Self-checking bench for pin decode and power sequencing
// Assumes: One millisecond shortened to MS cycles
// Notes:   Registers reached over APB, pins through the GPIO model
`timescale 1ns/1ps
`default_nettype none
module tcp_ctrl_test;
	localparam int MS = 40;
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	tcp_pkg::tcp_tri_t     lft = tcp_pkg::TRI_OPEN;
	tcp_pkg::tcp_tri_t     rgt = tcp_pkg::TRI_OPEN;
	logic                  lpu, lpd, rpu, rpd, ce, chan_en, rx_ind;
	logic                  det_en, sq_en, t_open, pready, pslverr;
	logic                  idle_a = 1'b0;
	logic                  idle_b = 1'b0;
	logic                  ft_a = 1'b0;
	logic                  ft_b = 1'b0;
	logic                  psel = 1'b0;
	logic                  penable = 1'b0;
	logic                  pwrite = 1'b0;
	logic [11:0]           paddr = 12'h000;
	logic [31:0]           pwdata = 32'h0;
	logic [31:0]           prdata, rdata;
	logic                  rerr;
	logic [1:0]            t_pres, eq_a, eq_b;
	tcp_pkg::tcp_state_t   state;
	tcp_pkg::tcp_tx_prof_t tx_a, tx_b;
	int                    num_errors = 0;
	int                    samples_checked = 0;
	int                    waited;

	always #12.5 clk = ~clk;

	tcp_gpio_model i_tcp_gpio_model (.left_lvl(lft), .right_lvl(rgt),
		.left_pu(lpu), .left_pd(lpd), .right_pu(rpu), .right_pd(rpd));

	tcp_ctrl #(.MS_CYCLES(MS)) i_tcp_ctrl (.REF_CLK(clk), .RST_N(rst_n),
		.LEFT_SIDE_CONFIG_PIN_PU(lpu), .LEFT_SIDE_CONFIG_PIN_PD(lpd),
		.RIGHT_SIDE_CONFIG_PIN_PU(rpu), .RIGHT_SIDE_CONFIG_PIN_PD(rpd),
		.LINK_IDLE_A(idle_a), .LINK_IDLE_B(idle_b), .FAR_TERM_A(ft_a),
		.FAR_TERM_B(ft_b), .CHIP_EN(ce), .POWER_STATE(state),
		.CHAN_EN(chan_en), .RX_TERM_IND(rx_ind), .TERM_DET_EN(det_en),
		.SQUELCH_DET_EN(sq_en), .TERM_OPEN(t_open), .TERM_PRESENT(t_pres),
		.CHA_TX_PROFILE(tx_a), .CHB_TX_PROFILE(tx_b),
		.CHA_RX_EQUALIZATION_GAIN(eq_a), .CHB_RX_EQUALIZATION_GAIN(eq_b),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr));

	function automatic logic [3:0] tx_of(input int t);
		case (t)
		2: tx_of = {tcp_pkg::DE_5P3, tcp_pkg::SW_1V1};
		1: tx_of = {tcp_pkg::DE_3P1, tcp_pkg::SW_1V0};
		default: tx_of = {tcp_pkg::DE_0DB, tcp_pkg::SW_0V9};
		endcase
	endfunction

	function automatic logic [1:0] eq_of(input int t);
		case (t)
		2: eq_of = tcp_pkg::EQ_9DB;
		1: eq_of = tcp_pkg::EQ_6DB;
		default: eq_of = tcp_pkg::EQ_3DB;
		endcase
	endfunction

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic timeout;
		num_errors++;
		$display("wait limit reached at %0t ns", $time);
		end_sim;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t ns: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	// Idle cycle first so psel never gets two values in one step
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			timeout();
	endtask

	task automatic wait_state(input tcp_pkg::tcp_state_t s, input int lim);
		waited = 0;
		while (state !== s && waited < lim) begin
			@(posedge clk);
			waited++;
		end
		if (waited >= lim)
			timeout();
	endtask

	task automatic pins(input int l, input int r);
		lft <= tcp_pkg::tcp_tri_t'(l[1:0]);
		rgt <= tcp_pkg::tcp_tri_t'(r[1:0]);
	endtask

	task automatic check_prof(input int l, input int r);
		check(32'(tx_a), 32'(tx_of(l)));
		check(32'(eq_b), 32'(eq_of(l)));
		check(32'(tx_b), 32'(tx_of(r)));
		check(32'(eq_a), 32'(eq_of(r)));
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (30) @(posedge clk);
		check(32'(state), 32'h3);
		check_prof(1, 1);
		check(32'({pready, pslverr}), 32'h2);
		apb(tcp_pkg::REG_STATUS, 1'b0, 32'h0);
		check(rdata, 32'h557);
		apb(tcp_pkg::REG_STATUS, 1'b1, 32'hffff_ffff);
		apb(tcp_pkg::REG_STATUS, 1'b0, 32'h0);
		check(rdata, 32'h557);
		apb(tcp_pkg::REG_CTRL, 1'b0, 32'h0);
		check(rdata, 32'h0001_2c00);
		apb(12'h008, 1'b0, 32'h0);
		check({rdata[30:0], rerr}, 32'h1);
		$display("test reset and registers done");

		for (int l = 0; l < 3; l++) begin
			for (int r = 0; r < 3; r++) begin
				if (l == 0 && r == 0)
					continue;
				pins(l, r);
				repeat (30) @(posedge clk);
				apb(tcp_pkg::REG_CTRL, 1'b1, 32'h1);
				repeat (3) @(posedge clk);
				check_prof(l, r);
				apb(tcp_pkg::REG_STATUS, 1'b0, 32'h0);
				check(rdata, {22'h1, r[1:0], l[1:0], r[1:0], l[1:0],
					2'h3});
			end
		end
		apb(tcp_pkg::REG_CTRL, 1'b0, 32'h0);
		check(rdata, 32'h0001_2c00);
		$display("test profile table done");

		pins(0, 1);
		repeat (30) @(posedge clk);
		check_prof(2, 2);
		waited = 0;
		while (tx_a !== tx_of(0) && waited < 116 * MS) begin
			@(posedge clk);
			waited++;
		end
		if (waited >= 116 * MS)
			timeout();
		check_prof(0, 1);
		$display("test periodic latch done");

		pins(0, 0);
		repeat (30) @(posedge clk);
		check(32'(ce), 32'h0);
		wait_state(tcp_pkg::ST_DEEP, 116 * MS);
		check(32'({chan_en, t_open, rx_ind}), 32'h2);
		pins(2, 0);
		wait_state(tcp_pkg::ST_WAKE, MS);
		repeat (MS) @(posedge clk);
		pins(2, 1);
		wait_state(tcp_pkg::ST_ACTIVE, 7 * MS);
		check(32'(waited > 4 * MS), 32'h1);
		repeat (2) @(posedge clk);
		check_prof(2, 1);
		$display("test deep saving done");

		apb(tcp_pkg::REG_CTRL, 1'b1, 32'h0000_0400);
		check(32'({rx_ind, det_en}), 32'h2);
		idle_a <= 1'b1;
		idle_b <= 1'b1;
		wait_state(tcp_pkg::ST_SAVE, 6 * MS);
		check(32'(waited >= 3 * MS), 32'h1);
		check(32'({chan_en, det_en, sq_en, rx_ind}), 32'he);
		ft_b <= 1'b1;
		repeat (3) @(posedge clk);
		check(32'({t_pres, rx_ind}), 32'h5);
		apb(tcp_pkg::REG_STATUS, 1'b0, 32'h0);
		check(32'(rdata[12:11]), 32'h2);
		idle_a <= 1'b0;
		wait_state(tcp_pkg::ST_ACTIVE, 10);
		repeat (2) @(posedge clk);
		check(32'({det_en, sq_en, rx_ind}), 32'h1);
		$display("test power saving done");
		end_sim();
	end
endmodule
`default_nettype wire
